// >>> debug_port_sticky_errors.sv
// Purpose: Sticky error recording and access gating of a debug port.
// Assumes: Transactions arrive decoded on the link clock; access-port answers
//   arrive on the same link clock; flag clears come from the clk domain.
// Notes: Flags live on the link clock, where their causes are seen; clears
//   and the overrun-watch enable cross in from clk, flag copies cross out.
`timescale 1ns/100ps

// Operation
// - Each sticky flag stays set until the debugger clears it.
// - Compare-result flag latches and clears like the error flags.
// - After an error, current transaction finishes; later port accesses are discarded.
// - Two-wire answers error at once; scan-chain completes discarded transactions at once.
// - Read or write error, internal or from resource, sets the error flag.
// - Port access while debug power is off may set the error flag.
// - Overrun watch is active while its enable holds one.
// - In overrun watch, disallowed responses set the overrun flag.
// - Setting the overrun flag leaves the error flag untouched.
// - An overrun earlier transaction still completes and may set flags.
// - Two-wire port ignores a message whose header parity fails.
// - Two-wire write data parity failure sets the write-parity flag.
// - Write-parity flag faults all accesses except identity, control/status, abort.
// - Writing one to write-parity clear clears the write-parity flag.
// - Repeat counter stops at zero or with error or compare flag set.
module debug_port_sticky_errors (
  input wire logic clk,
  input wire logic resetn,
  input wire logic link_clk,
  input wire logic link_resetn,
  input wire logic variant,
  input wire logic req_valid,
  input wire logic req_port,
  input wire logic req_write,
  input wire logic [1:0] req_sel,
  input wire logic header_parity_ok,
  input wire logic data_parity_ok,
  input wire logic debug_power_on,
  input wire logic ap_done,
  input wire logic ap_error,
  input wire logic cmp_event,
  input wire logic overrun_watch_enable_set,
  input wire logic overrun_watch_enable_value,
  input wire logic clear_error,
  input wire logic clear_overrun,
  input wire logic clear_compare,
  input wire logic write_parity_clear,
  input wire logic repeat_load,
  input wire logic [11:0] repeat_value,
  output logic ap_start,
  output logic resp_valid,
  output logic [2:0] resp_code,
  output logic error_latch,
  output logic overrun_latch,
  output logic write_parity_latch,
  output logic compare_result_latch,
  output logic overrun_watch_enable,
  output logic [11:0] repeat_counter
);

  ////////////////////////////////////////////////////////////////////////////
  // Control domain: the overrun-watch enable and the clear events.

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      overrun_watch_enable <= sticky_pkg::FLAG_RESET;
    end else if (overrun_watch_enable_set) begin
      overrun_watch_enable <= overrun_watch_enable_value;
    end
  end

  logic l_watch;
  logic l_clr_err;
  logic l_clr_orun;
  logic l_clr_cmp;
  logic l_clr_wpar;

  level_sync u_watch_sync (
    .clk(link_clk),
    .resetn(link_resetn),
    .d(overrun_watch_enable),
    .q(l_watch)
  );

  toggle_sync u_clr_err (
    .src_clk(clk),
    .src_resetn(resetn),
    .src_pulse(clear_error),
    .dst_clk(link_clk),
    .dst_resetn(link_resetn),
    .dst_pulse(l_clr_err)
  );

  toggle_sync u_clr_orun (
    .src_clk(clk),
    .src_resetn(resetn),
    .src_pulse(clear_overrun),
    .dst_clk(link_clk),
    .dst_resetn(link_resetn),
    .dst_pulse(l_clr_orun)
  );

  toggle_sync u_clr_cmp (
    .src_clk(clk),
    .src_resetn(resetn),
    .src_pulse(clear_compare),
    .dst_clk(link_clk),
    .dst_resetn(link_resetn),
    .dst_pulse(l_clr_cmp)
  );

  toggle_sync u_clr_wpar (
    .src_clk(clk),
    .src_resetn(resetn),
    .src_pulse(write_parity_clear),
    .dst_clk(link_clk),
    .dst_resetn(link_resetn),
    .dst_pulse(l_clr_wpar)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: request decode.

  logic l_err_ff;
  logic l_orun_ff;
  logic l_wpar_ff;
  logic l_cmp_ff;
  sticky_pkg::link_state_e state_ff;
  logic busy_port_ff;

  // Debug-port registers that stay reachable while the write-parity flag is set.
  function automatic logic exempt_sel(input logic [1:0] sel);
    exempt_sel = (sel == sticky_pkg::SEL_IDENTITY) || (sel == sticky_pkg::SEL_CTRL_STAT) ||
                 (sel == sticky_pkg::SEL_ABORT);
  endfunction : exempt_sel

  logic two_wire;
  logic heard;
  logic busy;
  logic blocked;
  logic wpar_fault;
  logic data_bad;
  logic accept;
  logic overrun;

  assign two_wire = (variant == sticky_pkg::VARIANT_TWO_WIRE);
  assign heard = req_valid && (!two_wire || header_parity_ok);
  // The closing state counts as busy too, so a request there cannot start a port access the tracker ignores.
  assign busy = (state_ff != sticky_pkg::ST_IDLE);
  assign blocked = l_err_ff || l_orun_ff;
  assign wpar_fault = two_wire && l_wpar_ff && (req_port || !exempt_sel(req_sel));
  assign data_bad = two_wire && req_write && !data_parity_ok;
  // A new request while one is in flight would be answered WAIT, which the watch forbids.
  assign overrun = heard && busy && l_watch;
  assign accept = heard && req_port && !busy && !blocked && !wpar_fault && !data_bad;

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: transaction tracking and repeat counter.

  logic repeat_go;
  assign repeat_go = busy && ap_done && !ap_error && (repeat_counter != sticky_pkg::REPEAT_RESET) &&
                     !l_cmp_ff && !cmp_event && !l_err_ff;

  always_ff @(posedge link_clk or negedge link_resetn) begin
    if (!link_resetn) begin
      state_ff <= sticky_pkg::ST_IDLE;
      busy_port_ff <= 1'b0;
    end else begin
      case (state_ff)
        sticky_pkg::ST_IDLE: begin
          if (accept) begin
            state_ff <= sticky_pkg::ST_BUSY;
            busy_port_ff <= 1'b1;
          end
        end
        sticky_pkg::ST_BUSY: begin
          // The earlier transaction still runs to its end after an overrun.
          if (ap_done && !repeat_go) begin
            state_ff <= sticky_pkg::ST_DONE;
          end
        end
        sticky_pkg::ST_DONE: begin
          state_ff <= sticky_pkg::ST_IDLE;
          busy_port_ff <= 1'b0;
        end
        default: begin
          state_ff <= sticky_pkg::ST_IDLE;
          busy_port_ff <= 1'b0;
        end
      endcase
    end
  end

  logic l_load;
  toggle_sync u_load (
    .src_clk(clk),
    .src_resetn(resetn),
    .src_pulse(repeat_load),
    .dst_clk(link_clk),
    .dst_resetn(link_resetn),
    .dst_pulse(l_load)
  );

  // The load value is held static by software around the load, so it is read directly.
  always_ff @(posedge link_clk or negedge link_resetn) begin
    if (!link_resetn) begin
      repeat_counter <= sticky_pkg::REPEAT_RESET;
    end else if (l_load) begin
      repeat_counter <= repeat_value;
    end else if (repeat_go) begin
      repeat_counter <= repeat_counter - 12'h001;
    end
  end

  always_ff @(posedge link_clk or negedge link_resetn) begin
    if (!link_resetn) begin
      ap_start <= 1'b0;
    end else begin
      ap_start <= accept || repeat_go;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: sticky flags. A set in the clear cycle wins.

  always_ff @(posedge link_clk or negedge link_resetn) begin
    if (!link_resetn) begin
      l_err_ff <= sticky_pkg::FLAG_RESET;
    end else if ((busy && ap_done && ap_error) || (heard && req_port && !debug_power_on)) begin
      l_err_ff <= 1'b1;
    end else if (l_clr_err) begin
      l_err_ff <= 1'b0;
    end
  end

  always_ff @(posedge link_clk or negedge link_resetn) begin
    if (!link_resetn) begin
      l_orun_ff <= sticky_pkg::FLAG_RESET;
    end else if (overrun) begin
      l_orun_ff <= 1'b1;
    end else if (l_clr_orun) begin
      l_orun_ff <= 1'b0;
    end
  end

  always_ff @(posedge link_clk or negedge link_resetn) begin
    if (!link_resetn) begin
      l_wpar_ff <= sticky_pkg::FLAG_RESET;
    end else if (heard && data_bad) begin
      l_wpar_ff <= 1'b1;
    end else if (l_clr_wpar) begin
      l_wpar_ff <= 1'b0;
    end
  end

  always_ff @(posedge link_clk or negedge link_resetn) begin
    if (!link_resetn) begin
      l_cmp_ff <= sticky_pkg::FLAG_RESET;
    end else if (cmp_event) begin
      l_cmp_ff <= 1'b1;
    end else if (l_clr_cmp) begin
      l_cmp_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: responses.

  always_ff @(posedge link_clk or negedge link_resetn) begin
    if (!link_resetn) begin
      resp_valid <= 1'b0;
      resp_code <= sticky_pkg::RESP_NONE;
    end else begin
      resp_valid <= heard;
      if (!heard) begin
        resp_code <= sticky_pkg::RESP_NONE;
      end else if (wpar_fault || data_bad) begin
        resp_code <= sticky_pkg::RESP_FAULT;
      end else if (busy) begin
        resp_code <= sticky_pkg::RESP_WAIT;
      end else if (req_port && blocked) begin
        // Two-wire reports the error; scan-chain claims the discarded access done.
        resp_code <= two_wire ? sticky_pkg::RESP_FAULT : sticky_pkg::RESP_OK;
      end else begin
        resp_code <= sticky_pkg::RESP_OK;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flag copies toward the control domain.

  level_sync u_err_out (.clk(clk), .resetn(resetn), .d(l_err_ff), .q(error_latch));
  level_sync u_orun_out (.clk(clk), .resetn(resetn), .d(l_orun_ff), .q(overrun_latch));
  level_sync u_wpar_out (.clk(clk), .resetn(resetn), .d(l_wpar_ff), .q(write_parity_latch));
  level_sync u_cmp_out (.clk(clk), .resetn(resetn), .d(l_cmp_ff), .q(compare_result_latch));

endmodule : debug_port_sticky_errors

// >>> sticky_pkg.sv
// Purpose: Shared constants and types for the debug port sticky error logic.
// Assumes: Link-side logic runs on the serial clock, control side on clk.
// Notes: Response codes follow the usual three-bit acknowledge encoding.
package sticky_pkg;

  // Link variants.
  localparam logic VARIANT_SCAN = 1'b0;
  localparam logic VARIANT_TWO_WIRE = 1'b1;

  // Responses that a transaction may end with.
  typedef enum logic [2:0] {
    RESP_OK = 3'h1,
    RESP_WAIT = 3'h2,
    RESP_FAULT = 3'h4,
    RESP_NONE = 3'h7
  } resp_e;

  // Debug port register selectors carried with a debug-port access.
  localparam logic [1:0] SEL_IDENTITY = 2'h0;
  localparam logic [1:0] SEL_CTRL_STAT = 2'h1;
  localparam logic [1:0] SEL_OTHER = 2'h2;
  localparam logic [1:0] SEL_ABORT = 2'h3;

  // Reset values of every flag, the overrun-watch enable and the repeat counter; counter width.
  localparam logic FLAG_RESET = 1'b0;
  localparam logic [11:0] REPEAT_RESET = 12'h000;
  localparam int REPEAT_W = 12;

  // Link-side transaction state.
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_BUSY = 2'h1,
    ST_DONE = 2'h3
  } link_state_e;

endpackage : sticky_pkg

// >>> level_sync.sv
// Purpose: Two-flop synchroniser for a single level.
// Assumes: The input is a level that holds for several destination clocks.
// Notes: The first flop feeds only the second.
`timescale 1ns/100ps
module level_sync (
  input wire logic clk,
  input wire logic resetn,
  input wire logic d,
  output logic q
);

  logic meta_ff;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_ff <= 1'b0;
      q <= 1'b0;
    end else begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end

endmodule : level_sync

// >>> toggle_sync.sv
// Purpose: Carries single-cycle events from one clock domain to another.
// Assumes: Events in the source are spaced wider than three destination clocks.
// Notes: A toggle flop crosses; an edge on the synchronised copy is the event.
`timescale 1ns/100ps
module toggle_sync (
  input wire logic src_clk,
  input wire logic src_resetn,
  input wire logic src_pulse,
  input wire logic dst_clk,
  input wire logic dst_resetn,
  output logic dst_pulse
);

  logic tog_ff;
  logic meta_ff;
  logic sync_ff;
  logic last_ff;

  always_ff @(posedge src_clk or negedge src_resetn) begin
    if (!src_resetn) begin
      tog_ff <= 1'b0;
    end else if (src_pulse) begin
      tog_ff <= ~tog_ff;
    end
  end

  always_ff @(posedge dst_clk or negedge dst_resetn) begin
    if (!dst_resetn) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
      dst_pulse <= 1'b0;
    end else begin
      meta_ff <= tog_ff;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
      dst_pulse <= sync_ff ^ last_ff;
    end
  end

endmodule : toggle_sync

// >>> ap_model.sv
// Purpose: Access port stand-in that answers started transactions.
// Assumes: ap_start is a one link cycle pulse.
// Notes: lat sets the answer delay, fail marks the answer as an error.
`timescale 1ns/100ps
module ap_model (
  input wire logic link_clk,
  input wire logic ap_start,
  input wire logic [3:0] lat,
  input wire logic fail,
  output logic ap_done,
  output logic ap_error
);
  logic [3:0] cnt_ff = 4'h0;
  initial ap_done = 1'b0;
  initial ap_error = 1'b0;
  // The error line carries nothing between answers, so it toggles there.
  always @(negedge link_clk) begin
    ap_done <= 1'b0;
    ap_error <= ~ap_error;
    if (ap_start) begin
      cnt_ff <= lat;
    end else if (cnt_ff == 4'h1) begin
      ap_done <= 1'b1;
      ap_error <= fail;
      cnt_ff <= 4'h0;
    end else if (cnt_ff != 4'h0) begin
      cnt_ff <= cnt_ff - 4'h1;
    end
  end
endmodule : ap_model

// >>> debug_port_sticky_errors_asserts.sv
// Purpose: Concurrent checks on the sticky error ports.
// Assumes: Flag copies trail the link flags by a few clk cycles.
// Notes: A clear may take up to 400 clk cycles to show on a flag.
`timescale 1ns/100ps
module sticky_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire logic link_clk,
  input wire logic link_resetn,
  input wire logic variant,
  input wire logic req_valid,
  input wire logic req_port,
  input wire logic header_parity_ok,
  input wire logic debug_power_on,
  input wire logic ap_done,
  input wire logic ap_error,
  input wire logic cmp_event,
  input wire logic clear_error,
  input wire logic clear_overrun,
  input wire logic resp_valid,
  input wire logic [2:0] resp_code,
  input wire logic error_latch,
  input wire logic overrun_latch,
  input wire logic compare_result_latch,
  input wire logic overrun_watch_enable
);
  logic [8:0] age_e_ff;
  logic [8:0] age_o_ff;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) age_e_ff <= 9'h1FF;
    else if (clear_error) age_e_ff <= 9'h000;
    else if (age_e_ff != 9'h1FF) age_e_ff <= age_e_ff + 9'h001;
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) age_o_ff <= 9'h1FF;
    else if (clear_overrun) age_o_ff <= 9'h000;
    else if (age_o_ff != 9'h1FF) age_o_ff <= age_o_ff + 9'h001;
  end
  answer_given_a: assert property (@(posedge link_clk) disable iff (!link_resetn)
    req_valid && (!variant || header_parity_ok) |=> resp_valid) else $error("request not answered");
  header_silent_a: assert property (@(posedge link_clk) disable iff (!link_resetn)
    req_valid && variant && !header_parity_ok |=> !resp_valid) else $error("bad header answered");
  resp_legal_a: assert property (@(posedge link_clk) disable iff (!link_resetn)
    resp_valid |-> resp_code inside {3'h1, 3'h2, 3'h4}) else $error("illegal response code");
  ap_error_sets_a: assert property (@(posedge link_clk) disable iff (!link_resetn)
    ap_done && ap_error |-> ##[1:3] error_latch) else $error("port error not latched");
  power_off_sets_a: assert property (@(posedge link_clk) disable iff (!link_resetn)
    req_valid && req_port && !variant && !debug_power_on && !overrun_latch |-> ##[1:3] error_latch)
    else $error("power off access not latched");
  compare_sets_a: assert property (@(posedge link_clk) disable iff (!link_resetn)
    cmp_event |-> ##[1:3] compare_result_latch) else $error("compare not latched");
  overrun_sets_a: assert property (@(posedge link_clk) disable iff (!link_resetn)
    resp_valid && resp_code == 3'h2 && overrun_watch_enable |-> ##[0:2] overrun_latch)
    else $error("overrun not latched");
  error_holds_a: assert property (@(posedge clk) disable iff (!resetn)
    $fell(error_latch) |-> age_e_ff < 9'h190) else $error("error flag dropped unasked");
  overrun_holds_a: assert property (@(posedge clk) disable iff (!resetn)
    $fell(overrun_latch) |-> age_o_ff < 9'h190) else $error("overrun flag dropped unasked");
  reset_clear_a: assert property (@(posedge clk) disable iff (!resetn)
    $rose(resetn) |-> !(error_latch | overrun_latch | compare_result_latch | overrun_watch_enable))
    else $error("flag set out of reset");
  cover property (@(posedge link_clk) ap_done && ap_error);
  cover property (@(posedge link_clk) resp_valid && resp_code == 3'h2);
  cover property (@(posedge link_clk) resp_valid && resp_code == 3'h4);
endmodule : sticky_checker
////////////////////////////////////////////////////////////////////////
bind debug_port_sticky_errors sticky_checker i_chk (.*);

// >>> debug_port_sticky_errors_tb.sv
// Purpose: Self-checking bench for the sticky error block.
// Assumes: Clears reach the flags within eight link cycles.
// Notes: Inputs change on falling edges of link_clk or clk, never on a rising edge.
`timescale 1ns/100ps
module debug_port_sticky_errors_tb;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic resetn, link_resetn, variant, req_valid, req_port, req_write, header_parity_ok, data_parity_ok;
  logic debug_power_on, ap_done, ap_error, cmp_event, overrun_watch_enable_set, overrun_watch_enable_value;
  logic clear_error, clear_overrun, clear_compare, write_parity_clear, repeat_load, fail, got_v, got_s;
  logic ap_start, resp_valid, error_latch, overrun_latch, write_parity_latch, compare_result_latch;
  logic overrun_watch_enable;
  logic [1:0] req_sel;
  logic [2:0] resp_code, got_c;
  logic [3:0] lat;
  logic [11:0] repeat_value, repeat_counter;
  int miscompares = 0, cmp_count = 0, starts = 0, ticks = 0;
  debug_port_sticky_errors i_dut (.*);
  ap_model i_ap (.*);
  always #2 clk = ~clk;
  initial begin
    #7;
    forever #80 link_clk = ~link_clk;
  end
  always @(negedge link_clk) if (ap_start) starts++;
  always @(posedge clk) begin
    ticks++;
    if (ticks == 60000) begin
      miscompares++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task check(input string name, input logic [11:0] seen, input logic [11:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check
  task conclude;
    $display("Checks %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  task lwait(input int n);
    repeat (n) @(negedge link_clk);
  endtask : lwait
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask : pulse
  task do_reset(input logic v);
    resetn = 1'b0;
    link_resetn = 1'b0;
    variant = v;
    repeat (20) @(negedge clk);
    lwait(2);
    @(negedge clk);
    resetn = 1'b1;
    link_resetn = 1'b1;
    lwait(3);
  endtask : do_reset
  task req(input logic p, input logic w, input logic [1:0] s, input logic hp, input logic dp);
    @(negedge link_clk);
    {req_valid, req_port, req_write, req_sel, header_parity_ok, data_parity_ok} = {1'b1, p, w, s, hp, dp};
    // The answer stands for one link cycle only, so it is taken at the first falling edge.
    @(negedge link_clk);
    {got_v, got_c, got_s} = {resp_valid, resp_code, ap_start};
    {req_valid, header_parity_ok, data_parity_ok} = 3'h3;
  endtask : req
  task t_error;
    fail = 1'b1;
    req(1'b1, 1'b0, 2'h0, 1'b1, 1'b1);
    lwait(8);
    fail = 1'b0;
    check("error set", error_latch, 1'h1);
    req(1'b1, 1'b0, 2'h0, 1'b1, 1'b1);
    check("discard code", got_c, sticky_pkg::RESP_OK);
    check("discard start", got_s, 1'h0);
    lwait(8);
    check("error held", error_latch, 1'h1);
    pulse(clear_error);
    lwait(8);
    check("error cleared", error_latch, 1'h0);
    req(1'b1, 1'b0, 2'h0, 1'b1, 1'b1);
    check("resumed start", got_s, 1'h1);
    lwait(6);
  endtask : t_error
  task t_power;
    debug_power_on = 1'b0;
    req(1'b1, 1'b0, 2'h0, 1'b1, 1'b1);
    debug_power_on = 1'b1;
    lwait(8);
    check("power error", error_latch, 1'h1);
    pulse(clear_error);
    lwait(8);
  endtask : t_power
  task t_compare;
    @(negedge link_clk);
    cmp_event = 1'b1;
    @(negedge link_clk);
    cmp_event = 1'b0;
    lwait(8);
    check("compare set", compare_result_latch, 1'h1);
    pulse(clear_compare);
    lwait(8);
    check("compare cleared", compare_result_latch, 1'h0);
  endtask : t_compare
  task t_overrun;
    {lat, starts, overrun_watch_enable_value} = {4'hA, 32'h0, 1'b1};
    pulse(overrun_watch_enable_set);
    lwait(8);
    check("watch on", overrun_watch_enable, 1'h1);
    req(1'b1, 1'b0, 2'h0, 1'b1, 1'b1);
    req(1'b1, 1'b0, 2'h0, 1'b1, 1'b1);
    check("busy code", got_c, sticky_pkg::RESP_WAIT);
    lwait(4);
    check("overrun set", overrun_latch, 1'h1);
    lwait(12);
    check("error kept", error_latch, 1'h0);
    check("first done once", starts[11:0], 12'h001);
    pulse(clear_overrun);
    lwait(8);
    check("overrun cleared", overrun_latch, 1'h0);
    {lat, overrun_watch_enable_value} = {4'h2, 1'b0};
    pulse(overrun_watch_enable_set);
    lwait(8);
    check("watch off", overrun_watch_enable, 1'h0);
  endtask : t_overrun
  task t_repeat(input logic f, input logic [11:0] n, input logic [11:0] left);
    {starts, repeat_value} = {32'h0, 12'h002};
    pulse(repeat_load);
    lwait(6);
    fail = f;
    req(1'b1, 1'b0, 2'h0, 1'b1, 1'b1);
    lwait(16);
    fail = 1'b0;
    check("repeat starts", starts[11:0], n);
    check("repeat left", repeat_counter, left);
    pulse(clear_error);
    lwait(8);
  endtask : t_repeat
  task t_two_wire;
    req(1'b0, 1'b0, sticky_pkg::SEL_IDENTITY, 1'b0, 1'b1);
    check("bad header", got_v, 1'h0);
    lwait(4);
    req(1'b0, 1'b0, sticky_pkg::SEL_IDENTITY, 1'b1, 1'b1);
    check("identity alive", got_v, 1'h1);
    req(1'b0, 1'b0, sticky_pkg::SEL_IDENTITY, 1'b1, 1'b1);
    check("retry code", got_c, sticky_pkg::RESP_OK);
    req(1'b1, 1'b1, 2'h0, 1'b1, 1'b0);
    lwait(8);
    check("parity flag", write_parity_latch, 1'h1);
    req(1'b1, 1'b0, 2'h0, 1'b1, 1'b1);
    check("parity port", got_c, sticky_pkg::RESP_FAULT);
    for (int s = 0; s < 4; s++) begin
      req(1'b0, 1'b0, s[1:0], 1'b1, 1'b1);
      check("parity dp", got_c, (s == 2) ? sticky_pkg::RESP_FAULT : sticky_pkg::RESP_OK);
    end
    pulse(write_parity_clear);
    lwait(8);
    check("parity cleared", write_parity_latch, 1'h0);
    fail = 1'b1;
    req(1'b1, 1'b0, 2'h0, 1'b1, 1'b1);
    lwait(8);
    fail = 1'b0;
    req(1'b1, 1'b0, 2'h0, 1'b1, 1'b1);
    check("error fault", got_c, sticky_pkg::RESP_FAULT);
  endtask : t_two_wire
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {req_valid, req_port, req_write, req_sel, cmp_event, fail} = 7'h00;
    {overrun_watch_enable_set, overrun_watch_enable_value, clear_error, clear_overrun} = 4'h0;
    {clear_compare, write_parity_clear, repeat_load, repeat_value} = 15'h0000;
    {header_parity_ok, data_parity_ok, debug_power_on, lat} = {3'h7, 4'h2};
    do_reset(1'b0);
    check("reset state", {error_latch, overrun_latch, write_parity_latch, compare_result_latch,
      overrun_watch_enable, resp_code, repeat_counter[3:0]}, 12'h070);
    t_error();
    t_power();
    t_compare();
    t_overrun();
    t_repeat(1'b0, 12'h003, 12'h000);
    t_repeat(1'b1, 12'h001, 12'h002);
    do_reset(1'b1);
    t_two_wire();
    conclude();
  end
endmodule : debug_port_sticky_errors_tb
